// ---- rtl/uh_device.sv ----
// Transceiver end: host register port, baud generator, transmitter and receiver.
// Assumes clk is the oscillator input and every pin is synchronous to it.
`timescale 1ns/1ps
`include "uh_consts.svh"
module uh_device (
	// Oscillator clock and reset.
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Pins toward host and line.
	uh_if.dev          bus,
	// Receive status for local use.
	output logic       rx_data_ready,
	output logic [7:0] rx_data
);
	typedef struct packed {
		logic [15:0]    div;
		logic [15:0]    bcnt;
		logic           baud_n;
		logic [7:0]     lcr;
		logic [7:0]     mcr;
		logic [7:0]     scr;
		logic [7:0]     rhr;
		logic           dr;
		logic           ovr;
		logic           pe;
		logic           fe;
		logic [5:0]     held;
		logic           wr_prev;
		logic           rd_prev;
		logic           sel_out;
		logic           transceiver_drive_disable_n;
		logic           dout_oe;
		logic [7:0]     dout;
		logic           txo;
		uh_pkg::uh_ser_e tst;
		logic [3:0]     ttick;
		logic [2:0]     tbit;
		logic [7:0]     tsh;
		logic           tline;
		logic           tpar;
		uh_pkg::uh_ser_e rsm;
		logic [3:0]     rtick;
		logic [2:0]     rbit;
		logic [7:0]     rsh;
		logic           rpar;
		logic           rclk_prev;
	} uh_dev_s;

	uh_dev_s    q;
	uh_dev_s    n;
	logic [5:0] live;
	logic [5:0] eff;
	logic       sel;
	logic       wr_act;
	logic       rd_act;
	logic       wr_go;
	logic       rd_go;
	logic       dlab;
	logic       tick;
	logic       rtk;
	logic       rxs;
	logic [2:0] last_bit;
	logic [7:0] masked;
	logic       buf_in_valid;
	logic       buf_in_ready;
	logic       buf_out_valid;
	logic       buf_out_ready;
	logic [7:0] buf_out_data;

	function automatic logic [7:0] word_mask(input logic [1:0] wlen);
		return 8'(8'hFF >> (2'd3 - wlen));
	endfunction

	uh_buf2 #(.W(8), .DEPTH(2)) u_txbuf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (bus.host_data_bus),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	always_comb begin
		n = q;
		live = {bus.select_high_first, bus.select_high_second, bus.select_low_third,
			bus.register_select_lines};
		eff = bus.address_latch_strobe ? q.held : live;
		if (!bus.address_latch_strobe) begin
			n.held = live;
		end
		sel = eff[5] & eff[4] & ~eff[3];
		wr_act = ~bus.write_strobe_low | bus.write_strobe_high;
		rd_act = ~bus.read_strobe_low | bus.read_strobe_high;
		wr_go = sel & wr_act & ~q.wr_prev;
		rd_go = sel & rd_act & ~q.rd_prev;
		n.wr_prev = sel & wr_act;
		n.rd_prev = sel & rd_act;
		dlab = q.lcr[`UH_LCR_DLAB];
		buf_in_valid = wr_go && eff[2:0] == `UH_REG_DATA && !dlab;
		if (wr_go) begin
			unique case (eff[2:0])
				`UH_REG_DATA:  if (dlab) n.div[7:0] = bus.host_data_bus;
				`UH_REG_DIVHI: if (dlab) n.div[15:8] = bus.host_data_bus;
				`UH_REG_LCR:   n.lcr = bus.host_data_bus;
				`UH_REG_MCR:   n.mcr = bus.host_data_bus;
				`UH_REG_SCR:   n.scr = bus.host_data_bus;
				default:       n.scr = q.scr;
			endcase
		end
		if (rd_go) begin
			unique case (eff[2:0])
				`UH_REG_DATA: begin
					n.dout = dlab ? q.div[7:0] : q.rhr;
					if (!dlab) n.dr = 1'b0;
				end
				`UH_REG_DIVHI: n.dout = dlab ? q.div[15:8] : 8'h00;
				`UH_REG_LCR:   n.dout = q.lcr;
				`UH_REG_MCR:   n.dout = q.mcr;
				`UH_REG_LSR: begin
					n.dout = {1'b0, !buf_out_valid && q.tst == uh_pkg::SER_IDLE,
						buf_in_ready, 1'b0, q.fe, q.pe, q.ovr, q.dr};
					n.ovr = 1'b0;
					n.pe  = 1'b0;
					n.fe  = 1'b0;
				end
				`UH_REG_SCR:   n.dout = q.scr;
				default:       n.dout = 8'h00;
			endcase
		end
		n.sel_out = sel;
		n.dout_oe = sel & rd_act;
		n.transceiver_drive_disable_n  = ~(sel & rd_act);

		// Baud generator: one tick per divisor count of the oscillator.
		tick = 1'b0;
		if (q.bcnt <= 16'h0001) begin
			n.bcnt = q.div;
			tick = q.div != 16'h0000;
		end else begin
			n.bcnt = q.bcnt - 16'h0001;
		end
		n.baud_n = ~tick;

		// Transmitter, sixteen ticks per bit.
		last_bit = 3'(q.lcr[1:0]) + 3'h4;
		masked = buf_out_data & word_mask(q.lcr[1:0]);
		buf_out_ready = q.tst == uh_pkg::SER_IDLE;
		if (q.tst == uh_pkg::SER_IDLE) begin
			if (buf_out_valid) begin
				n.tsh = masked;
				n.tpar = q.lcr[`UH_LCR_EPS] ? ^masked : ~^masked;
				n.tst = uh_pkg::SER_START;
				n.ttick = 4'h0;
				n.tline = 1'b0;
			end
		end else if (tick) begin
			n.ttick = q.ttick + 4'h1;
			if (q.ttick == `UH_LAST_TICK) begin
				unique case (q.tst)
					uh_pkg::SER_START: begin
						n.tst = uh_pkg::SER_DATA;
						n.tbit = 3'h0;
						n.tline = q.tsh[0];
					end
					uh_pkg::SER_DATA: begin
						n.tsh = q.tsh >> 1;
						n.tbit = q.tbit + 3'h1;
						n.tline = q.tsh[1];
						if (q.tbit == last_bit) begin
							n.tbit = 3'h0;
							n.tst = q.lcr[`UH_LCR_PEN] ? uh_pkg::SER_PAR : uh_pkg::SER_STOP;
							n.tline = q.lcr[`UH_LCR_PEN] ? q.tpar : 1'b1;
						end
					end
					uh_pkg::SER_PAR: begin
						n.tst = uh_pkg::SER_STOP;
						n.tline = 1'b1;
					end
					uh_pkg::SER_STOP: begin
						if (q.lcr[`UH_LCR_STOP2] && q.tbit == 3'h0) n.tbit = 3'h1;
						else n.tst = uh_pkg::SER_IDLE;
					end
					uh_pkg::SER_IDLE: n.tst = uh_pkg::SER_IDLE;
				endcase
			end
		end
		n.txo = n.mcr[`UH_MCR_LOOP] ? 1'b1 : n.tline;

		// Receiver, ticked by rising edges of the receive clock input.
		n.rclk_prev = bus.rx_clock_in;
		rtk = bus.rx_clock_in & ~q.rclk_prev;
		rxs = q.mcr[`UH_MCR_LOOP] ? q.tline : bus.serial_to_dev;
		if (rtk) begin
			n.rtick = q.rtick + 4'h1;
			unique case (q.rsm)
				uh_pkg::SER_IDLE: begin
					n.rtick = 4'h0;
					if (!rxs) n.rsm = uh_pkg::SER_START;
				end
				uh_pkg::SER_START: begin
					if (q.rtick == `UH_MID_TICK) begin
						n.rtick = 4'h0;
						n.rbit = 3'h0;
						n.rsh = 8'h00;
						n.rpar = 1'b0;
						n.rsm = rxs ? uh_pkg::SER_IDLE : uh_pkg::SER_DATA;
					end
				end
				uh_pkg::SER_DATA: begin
					if (q.rtick == `UH_LAST_TICK) begin
						n.rsh[q.rbit] = rxs;
						n.rpar = q.rpar ^ rxs;
						n.rbit = q.rbit + 3'h1;
						if (q.rbit == last_bit) begin
							n.rsm = q.lcr[`UH_LCR_PEN] ? uh_pkg::SER_PAR : uh_pkg::SER_STOP;
						end
					end
				end
				uh_pkg::SER_PAR: begin
					if (q.rtick == `UH_LAST_TICK) begin
						n.rpar = q.rpar ^ rxs ^ ~q.lcr[`UH_LCR_EPS];
						n.rsm = uh_pkg::SER_STOP;
					end
				end
				uh_pkg::SER_STOP: begin
					if (q.rtick == `UH_LAST_TICK) begin
						n.rhr = q.rsh;
						n.ovr = q.dr | n.ovr;
						n.dr = 1'b1;
						n.pe = (q.lcr[`UH_LCR_PEN] & q.rpar) | n.pe;
						n.fe = ~rxs | n.fe;
						n.rsm = uh_pkg::SER_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.div <= `UH_DIV_RST;
			q.lcr <= `UH_LCR_RST;
			q.mcr <= `UH_MCR_RST;
			q.baud_n <= 1'b1;
			q.transceiver_drive_disable_n <= 1'b1;
			q.txo <= 1'b1;
			q.tline <= 1'b1;
			q.held <= 6'h07;
			q.rclk_prev <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign bus.dev_bus_out               = q.dout;
	assign bus.dev_bus_oe                = q.dout_oe;
	assign bus.transceiver_drive_disable = q.transceiver_drive_disable_n;
	assign bus.selected_indicator        = q.sel_out;
	assign bus.serial_from_dev           = q.txo;
	assign bus.baud_16x_clock_out        = q.baud_n;
	assign rx_data_ready                 = q.dr;
	assign rx_data                       = q.rhr;
endmodule // uh_device

// ---- rtl/uh_consts.svh ----
// Constants of the serial transceiver: register offsets, fields, reset values, timing.
// Assumes inclusion by bare name from both ends and the bench.
// Summary of operation
// - Eight-bit data bus, bit zero sent first.
// - Serial high is one, low is zero.
// - Loopback feeds receiver from transmitter internally.
// - Serial output idles high in reset, loopback.
// - Frame: start, data, optional parity, stop bits.
// - Selected only when both highs, low select active.
// - Baud pin gives sixteen times programmed rate.
// - Receiver runs from the receive clock input.
// - Selected write strobe stores bus into register.
// - Either write strobe alone makes a write.
// - Either read strobe alone makes a read.
// - Drive disable low during every device read.
// - Selected indicator high while chip is selected.
// - Low address strobe captures selects and address.
// - Host without latching holds address strobe low.
// - Baud divisor covers slow through fastest rates.
// - Word length five to eight bits.
// - Even, odd or no parity, made and checked.
// - Oscillator clocks logic and baud generator.
// - Reset clears registers except divisor (loads 2) and line control (loads 03), and idles serial lines.
`ifndef UH_CONSTS_SVH
`define UH_CONSTS_SVH
`define UH_OSC_HZ      40000000
`define UH_REG_DATA    3'h0
`define UH_REG_DIVHI   3'h1
`define UH_REG_LCR     3'h3
`define UH_REG_MCR     3'h4
`define UH_REG_LSR     3'h5
`define UH_REG_SCR     3'h7
`define UH_LCR_STOP2   2
`define UH_LCR_PEN     3
`define UH_LCR_EPS     4
`define UH_LCR_DLAB    7
`define UH_MCR_LOOP    4
`define UH_LCR_RST     8'h03
`define UH_MCR_RST     8'h00
`define UH_DIV_RST     16'h0002
`define UH_MID_TICK    4'h7
`define UH_LAST_TICK   4'hF
`define UH_STROBE_CYC  3
`endif

// ---- rtl/uh_pkg.sv ----
// Types shared by both ends of the serial transceiver.
// Assumes nothing beyond the constants header.
package uh_pkg;
	typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} uh_ser_e;
	typedef enum logic [1:0] {HST_IDLE, HST_SETUP, HST_STROBE, HST_HOLD} uh_hst_e;
endpackage

// ---- rtl/uh_if.sv ----
// Pin bundle between the transceiver and its host and line partner.
// Resolves the shared data bus from both enables; an undriven bus reads high.
`timescale 1ns/1ps
interface uh_if;
	logic       select_high_first;
	logic       select_high_second;
	logic       select_low_third;
	logic       address_latch_strobe;
	logic [2:0] register_select_lines;
	logic       write_strobe_low;
	logic       write_strobe_high;
	logic       read_strobe_low;
	logic       read_strobe_high;
	logic [7:0] host_bus_out;
	logic       host_bus_oe;
	logic [7:0] dev_bus_out;
	logic       dev_bus_oe;
	logic [7:0] host_data_bus;
	logic       transceiver_drive_disable;
	logic       selected_indicator;
	logic       serial_to_dev;
	logic       serial_from_dev;
	logic       baud_16x_clock_out;
	logic       rx_clock_in;

	assign host_data_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 8'hFF);

	modport dev (
		input  select_high_first, select_high_second, select_low_third, address_latch_strobe,
		input  register_select_lines, write_strobe_low, write_strobe_high,
		input  read_strobe_low, read_strobe_high, host_data_bus, serial_to_dev, rx_clock_in,
		output dev_bus_out, dev_bus_oe, transceiver_drive_disable, selected_indicator,
		output serial_from_dev, baud_16x_clock_out
	);
	modport host (
		output select_high_first, select_high_second, select_low_third, address_latch_strobe,
		output register_select_lines, write_strobe_low, write_strobe_high,
		output read_strobe_low, read_strobe_high, host_bus_out, host_bus_oe, serial_to_dev,
		output rx_clock_in,
		input  host_data_bus, transceiver_drive_disable, selected_indicator,
		input  serial_from_dev, baud_16x_clock_out
	);
endinterface

// ---- rtl/uh_buf2.sv ----
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock; a push into a full buffer is not taken.
`timescale 1ns/1ps
module uh_buf2 #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} uh_buf_s;

	uh_buf_s q;
	uh_buf_s n;
	logic    push;
	logic    pop;

	assign in_ready  = q.cnt != (AW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data  = q.mem[q.rp];

	always_comb begin
		n    = q;
		push = in_valid && in_ready;
		pop  = out_valid && out_ready;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
		end
		if (pop) begin
			n.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
		end
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule // uh_buf2

// ---- rtl/uh_host.sv ----
// Host end: runs one register access at a time over the parallel pins.
// Assumes the board ties the receive clock to the baud pin, as done here.
`timescale 1ns/1ps
`include "uh_consts.svh"
module uh_host #(
	parameter int STROBE_CYC = `UH_STROBE_CYC
) (
	// Clock and reset.
	input  wire logic  clk,
	input  wire logic  rst_n,
	// Pins toward the transceiver.
	uh_if.host         bus,
	// Access requests.
	input  wire logic       req,
	input  wire logic       we,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wdata,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rdata,
	// Remote line partner.
	input  wire logic  line_tx,
	output logic       line_rx
);
	typedef struct packed {
		uh_pkg::uh_hst_e st;
		logic [3:0]     cnt;
		logic           we;
		logic [2:0]     addr;
		logic [7:0]     wdata;
		logic [7:0]     rdata;
		logic           done;
		logic           sel;
		logic           wr_n;
		logic           rd_n;
		logic           line_tx;
		logic           line_rx;
	} uh_hst_s;

	uh_hst_s q;
	uh_hst_s n;

	always_comb begin
		n = q;
		n.done = 1'b0;
		n.line_tx = line_tx;
		n.line_rx = bus.serial_from_dev;
		unique case (q.st)
			uh_pkg::HST_IDLE: begin
				if (req) begin
					n.st = uh_pkg::HST_SETUP;
					n.we = we;
					n.addr = addr;
					n.wdata = wdata;
					n.sel = 1'b1;
				end
			end
			uh_pkg::HST_SETUP: begin
				n.st = uh_pkg::HST_STROBE;
				n.cnt = 4'(STROBE_CYC - 1);
				n.wr_n = ~q.we;
				n.rd_n = q.we;
			end
			uh_pkg::HST_STROBE: begin
				n.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h0) begin
					n.st = uh_pkg::HST_HOLD;
					n.wr_n = 1'b1;
					n.rd_n = 1'b1;
					if (!q.we) n.rdata = bus.host_data_bus;
				end
			end
			uh_pkg::HST_HOLD: begin
				n.st = uh_pkg::HST_IDLE;
				n.sel = 1'b0;
				n.done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.wr_n <= 1'b1;
			q.rd_n <= 1'b1;
			q.line_tx <= 1'b1;
			q.line_rx <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign bus.select_high_first     = q.sel;
	assign bus.select_high_second    = q.sel;
	assign bus.select_low_third      = ~q.sel;
	assign bus.address_latch_strobe  = 1'b0;
	assign bus.register_select_lines = q.addr;
	assign bus.write_strobe_low      = q.wr_n;
	assign bus.write_strobe_high     = 1'b0;
	assign bus.read_strobe_low       = q.rd_n;
	assign bus.read_strobe_high      = 1'b0;
	assign bus.host_bus_out          = q.wdata;
	assign bus.host_bus_oe           = q.sel & q.we;
	assign bus.serial_to_dev         = q.line_tx;
	assign bus.rx_clock_in           = bus.baud_16x_clock_out;
	assign busy                      = q.st != uh_pkg::HST_IDLE;
	assign done                      = q.done;
	assign rdata                     = q.rdata;
	assign line_rx                   = q.line_rx;
endmodule // uh_host

// ---- tb/uh_asserts.sv ----
// Concurrent checks on the pins between the transceiver and its host end.
// Assumes one clock, asynchronous active-low reset, and a host that keeps the latch transparent.
`timescale 1ns/1ps
module uh_asserts (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Host side pins.
	input wire logic select_high_first,
	input wire logic select_high_second,
	input wire logic select_low_third,
	input wire logic address_latch_strobe,
	input wire logic read_strobe_low,
	input wire logic read_strobe_high,
	input wire logic write_strobe_high,
	input wire logic host_bus_oe,
	input wire logic dev_bus_oe,
	input wire logic transceiver_drive_disable,
	input wire logic selected_indicator,
	// Serial side pins.
	input wire logic serial_from_dev,
	input wire logic baud_16x_clock_out,
	input wire logic rx_clock_in
);
	logic       sel;
	logic [5:0] low_ticks;

	assign sel = select_high_first & select_high_second & !select_low_third;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Counts baud ticks over one low stretch of the serial output.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			low_ticks <= '0;
		else if (serial_from_dev)
			low_ticks <= '0;
		else if (!baud_16x_clock_out && low_ticks != 6'h3F)
			low_ticks <= low_ticks + 6'h01;
	end

	property p_sel;
		!$past(address_latch_strobe) |-> selected_indicator == $past(sel);
	endproperty
	a_sel: assert property (p_sel) else $error("selected indicator wrong");
	property p_transceiver_drive_disable;
		!$past(address_latch_strobe) |->
			transceiver_drive_disable == !$past(sel && (!read_strobe_low || read_strobe_high));
	endproperty
	a_transceiver_drive_disable: assert property (p_transceiver_drive_disable) else $error("drive disable wrong");
	property p_oe;
		dev_bus_oe == !transceiver_drive_disable;
	endproperty
	a_oe: assert property (p_oe) else $error("bus drive not matched to read");
	property p_clash;
		!(dev_bus_oe && host_bus_oe);
	endproperty
	a_clash: assert property (p_clash) else $error("both ends drive the data bus");
	property p_baud;
		!baud_16x_clock_out |=> baud_16x_clock_out;
	endproperty
	a_baud: assert property (p_baud) else $error("baud pin low too long");
	property p_tie;
		rx_clock_in == baud_16x_clock_out;
	endproperty
	a_tie: assert property (p_tie) else $error("receive clock not tied to baud pin");
	property p_hi_idle;
		!write_strobe_high && !read_strobe_high;
	endproperty
	a_hi_idle: assert property (p_hi_idle) else $error("unused strobe active");
	// Checked one edge on, since the pins are unknown until the first reset edge.
	property p_rst;
		disable iff (1'b0) !rst_n |=> serial_from_dev && baud_16x_clock_out
			&& transceiver_drive_disable && !selected_indicator && !dev_bus_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("pins not idle in reset");
	property p_bit_len;
		$rose(serial_from_dev) |-> low_ticks >= 6'd15;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("serial low shorter than a bit");

	c_read: cover property ($fell(transceiver_drive_disable));
	c_start: cover property ($fell(serial_from_dev));
	c_sel: cover property ($rose(selected_indicator));
endmodule // uh_asserts

// ---- tb/tb_top.sv ----
// Bench joining host end and transceiver end; drives host requests and the remote line.
// Assumes divisor left at its reset value, so one bit lasts 32 clocks.
`timescale 1ns/1ps
`include "uh_consts.svh"
module tb_top;
	localparam int BIT = 32;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       req = 1'b0;
	logic       we = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic       line_tx = 1'b1;
	logic       busy, done, line_rx, rx_rdy, bad;
	logic [7:0] rdata, rx_word, rd, v, w, lc;
	logic [2:0] ra[4] = '{3'h3, 3'h4, 3'h5, 3'h7};
	logic [7:0] rv[4] = '{8'h03, 8'h00, 8'h60, 8'h00};
	logic [7:0] q[$];
	int         n_errors = 0;
	int         checks_done = 0;
	int         seed = 14;

	always #12.5 clk = ~clk;

	uh_if bus ();
	uh_device i_uh_device (.clk(clk), .rst_n(rst_n), .bus(bus.dev), .rx_data_ready(rx_rdy),
		.rx_data(rx_word));
	uh_host i_uh_host (.clk(clk), .rst_n(rst_n), .bus(bus.host), .req(req), .we(we),
		.addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata),
		.line_tx(line_tx), .line_rx(line_rx));
	uh_asserts i_uh_asserts (.clk(clk), .rst_n(rst_n),
		.select_high_first(bus.select_high_first), .select_high_second(bus.select_high_second),
		.select_low_third(bus.select_low_third), .address_latch_strobe(bus.address_latch_strobe),
		.read_strobe_low(bus.read_strobe_low), .read_strobe_high(bus.read_strobe_high),
		.write_strobe_high(bus.write_strobe_high), .host_bus_oe(bus.host_bus_oe),
		.dev_bus_oe(bus.dev_bus_oe), .transceiver_drive_disable(bus.transceiver_drive_disable),
		.selected_indicator(bus.selected_indicator), .serial_from_dev(bus.serial_from_dev),
		.baud_16x_clock_out(bus.baud_16x_clock_out), .rx_clock_in(bus.rx_clock_in));

	task test_done();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	function logic [7:0] msk(input logic [7:0] l);
		return 8'hFF >> (3 - l[1:0]);
	endfunction

	function logic par(input logic [7:0] l, input logic [7:0] d);
		return l[4] ? ^(d & msk(l)) : ~^(d & msk(l));
	endfunction

	// One register access through the host end; waits for its done pulse.
	task acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
		int t;
		@(posedge clk);
		req <= 1'b1;
		we <= wr;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		req <= 1'b0;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (done !== 1'b1 && t < 20);
		if (t >= 20)
			chk("done", 8'h01, 8'h00);
		rd = rdata;
		chk("idle", 8'h00, {7'h0, busy});
	endtask

	// Sends one frame on the remote line; bad flips the parity bit.
	task txf(input logic [7:0] l, input logic [7:0] d, input logic bd);
		@(posedge clk);
		line_tx <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < 5 + l[1:0]; i++) begin
			line_tx <= d[i];
			repeat (BIT) @(posedge clk);
		end
		if (l[3]) begin
			line_tx <= par(l, d) ^ bd;
			repeat (BIT) @(posedge clk);
		end
		line_tx <= 1'b1;
		repeat (BIT * 2) @(posedge clk);
	endtask

	// Captures one frame from the line at bit centres and checks its framing.
	task rxf(input logic [7:0] l, output logic [7:0] x);
		int t;
		x = 8'h00;
		t = 0;
		while (line_rx !== 1'b0 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		repeat (BIT / 2) @(posedge clk);
		chk("start", 8'h00, {7'h0, line_rx});
		for (int i = 0; i < 5 + l[1:0]; i++) begin
			repeat (BIT) @(posedge clk);
			x[i] = line_rx;
		end
		if (l[3]) begin
			repeat (BIT) @(posedge clk);
			chk("parity", {7'h0, par(l, x)}, {7'h0, line_rx});
		end
		repeat (1 + l[2]) begin
			repeat (BIT) @(posedge clk);
			chk("stop", 8'h01, {7'h0, line_rx});
		end
	endtask

	task quiet(input string n);
		logic hi;
		hi = 1'b1;
		repeat (500) begin
			@(posedge clk);
			if (line_rx !== 1'b1)
				hi = 1'b0;
		end
		chk(n, 8'h01, {7'h0, hi});
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, ra[i], 8'h00);
			chk("reset value", rv[i], rd);
		end
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			lc = (i < 4) ? 8'h07 : ((i == 4) ? 8'h02 : 8'h06);
			acc(1'b1, lc[2:0], v);
			acc(1'b0, lc[2:0], 8'h00);
			chk("register", (i < 4) ? v : 8'h00, rd);
		end
		acc(1'b1, `UH_REG_LCR, 8'h83);
		acc(1'b0, `UH_REG_LCR, 8'h00);
		chk("lcr", 8'h83, rd);
		acc(1'b0, `UH_REG_DATA, 8'h00);
		chk("divisor low", 8'h02, rd);
		acc(1'b0, `UH_REG_DIVHI, 8'h00);
		chk("divisor high", 8'h00, rd);
		for (int m = 0; m < 32; m++) begin
			lc = m[7:0];
			v = 8'($random(seed));
			bad = 1'($random(seed));
			acc(1'b1, `UH_REG_LCR, lc);
			fork
				acc(1'b1, `UH_REG_DATA, v);
				rxf(lc, w);
			join
			chk("sent word", v & msk(lc), w);
			txf(lc, v, bad & lc[3]);
			chk("data ready", 8'h01, {7'h0, rx_rdy});
			chk("data out", v & msk(lc), rx_word);
			acc(1'b0, `UH_REG_LSR, 8'h00);
			chk("status", 8'h61 | {5'h0, bad & lc[3], 2'h0}, rd);
			acc(1'b0, `UH_REG_DATA, 8'h00);
			chk("received word", v & msk(lc), rd & msk(lc));
			acc(1'b0, `UH_REG_LSR, 8'h00);
			chk("status cleared", 8'h60, rd);
		end
		acc(1'b1, `UH_REG_LCR, 8'h03);
		acc(1'b1, `UH_REG_MCR, 8'h10);
		v = 8'($random(seed));
		line_tx <= 1'b0;
		acc(1'b1, `UH_REG_DATA, v);
		quiet("loop line");
		acc(1'b0, `UH_REG_DATA, 8'h00);
		chk("loop word", v, rd);
		line_tx <= 1'b1;
		acc(1'b1, `UH_REG_MCR, 8'h00);
		fork
			for (int i = 0; i < 3; i++) begin
				rxf(8'h03, w);
				chk("queued word", q[i], w);
			end
			begin
				for (int i = 0; i < 4; i++) begin
					v = 8'($random(seed));
					acc(1'b1, `UH_REG_DATA, v);
					if (i < 3)
						q.push_back(v);
				end
				acc(1'b0, `UH_REG_LSR, 8'h00);
				chk("buffer full", 8'h00, rd & 8'h60);
			end
		join
		quiet("dropped word");
		test_done();
	end
endmodule // tb_top
